// ### core/board_glue_defines.vh
`ifndef BOARD_GLUE_DEFINES_VH
`define BOARD_GLUE_DEFINES_VH

// =====================================================================
// Keypad
// =====================================================================
`define KEY_COUNT        5

// =====================================================================
// Clocking
// =====================================================================
`define SYS_CLK_HZ       1049100
`define SYS_CLK_TOL_HZ   525
`define RF_TICK_HZ       131075
`define RF_DIV           (`SYS_CLK_HZ / `RF_TICK_HZ)
`define RF_CNT_W         4

// =====================================================================
// Reset values of the driven outputs
// =====================================================================
`define RST_STOP_N       1'b1
`define RST_STOP_OE      1'b0
`define RST_IRQ          1'b0
`define RST_LOAD_EN      1'b0

`endif

// ### core/key_chord_detect.v
`timescale 1ns/1ps
`include "board_glue_defines.vh"

module key_chord_detect #(
  parameter KEYS = `KEY_COUNT
) (
  // Keys, high while pressed
  input  wire [KEYS-1:0] keys_pressed_i,
  // Decoded states
  output wire            chord_o,
  output wire            any_key_o
);

  // ===================================================================
  // Reduction chains
  // ===================================================================
  wire [KEYS:0] and_chain;
  wire [KEYS:0] or_chain;

  assign and_chain[0] = 1'b1;
  assign or_chain[0]  = 1'b0;

  genvar k;
  generate
    for (k = 0; k < KEYS; k = k + 1) begin : g_key
      assign and_chain[k+1] = and_chain[k] & keys_pressed_i[k];
      assign or_chain[k+1]  = or_chain[k] | keys_pressed_i[k];
    end
  endgenerate

  assign chord_o   = and_chain[KEYS];
  assign any_key_o = or_chain[KEYS];

endmodule // key_chord_detect

// ### core/converter_stop_ctrl.v
`timescale 1ns/1ps
`include "board_glue_defines.vh"

module converter_stop_ctrl (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_n_i,
  // Conditions
  input  wire supply_ok_i,
  input  wire receive_hush_mode_i,
  input  wire radio_receive_active_i,
  input  wire dummy_load_on_i,
  // Converter shutdown pin and backup state
  output reg  converter_stop_n_o,
  output reg  converter_stop_n_oe_o,
  output reg  backup_mode_o
);

  // ===================================================================
  // Stop decision
  // ===================================================================
  wire stop_req;

  assign stop_req = receive_hush_mode_i & radio_receive_active_i
                    & ~dummy_load_on_i;

  // ===================================================================
  // Pin drive
  // ===================================================================
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      converter_stop_n_o    <= `RST_STOP_N;
      converter_stop_n_oe_o <= `RST_STOP_OE;
      backup_mode_o         <= 1'b0;
    end else if (!supply_ok_i) begin
      converter_stop_n_o    <= `RST_STOP_N;
      converter_stop_n_oe_o <= `RST_STOP_OE;
      backup_mode_o         <= 1'b0;
    end else begin
      converter_stop_n_oe_o <= 1'b1;
      converter_stop_n_o    <= ~stop_req;
      backup_mode_o         <= stop_req;
    end
  end

endmodule // converter_stop_ctrl

// ### core/board_reset_irq_glue.v
`timescale 1ns/1ps
`include "board_glue_defines.vh"

module board_reset_irq_glue #(
  parameter KEYS    = `KEY_COUNT,
  parameter CLK_HZ  = `SYS_CLK_HZ,
  parameter RF_HZ   = `RF_TICK_HZ
) (
  // Clock and reset
  input  wire            clk_i,
  input  wire            rst_n_i,
  // Keypad
  input  wire [KEYS-1:0] keys_pressed_i,
  // Reset sources
  input  wire            watchdog_reset_req_i,
  input  wire            supply_low_reset_n_i,
  // Radio and power control
  input  wire            receive_hush_mode_i,
  input  wire            radio_receive_active_i,
  input  wire            dummy_load_on_i,
  input  wire            vibrator_req_i,
  input  wire            backlight_req_i,
  // Interrupt sources
  input  wire            battery_low_n_i,
  input  wire            serial_chip_irq_i,
  // Processor reset
  output wire            cpu_reset_out_o,
  // Converter shutdown pin
  output wire            converter_stop_n_o,
  output wire            converter_stop_n_oe_o,
  // Processor interrupts
  output reg             cpu_irq_in_a_o,
  output reg             cpu_irq_in_b_o,
  output reg             cpu_irq_in_c_o,
  // Load enables and status
  output reg             vibrator_en_o,
  output reg             backlight_en_o,
  output wire            backup_mode_o,
  output reg             loads_restored_o,
  output reg             sram_access_en_o,
  output reg  [2:0]      reset_cause_o,
  output reg             rf_tick_o
);

  // ===================================================================
  // Local constants
  // ===================================================================
  localparam integer RF_DIV_I = CLK_HZ / RF_HZ;
  localparam [`RF_CNT_W-1:0] RF_LAST = RF_DIV_I[`RF_CNT_W-1:0] - 1'b1;

  // ===================================================================
  // Keypad decode
  // ===================================================================
  wire keypad_chord_reset;
  wire keypad_irq;

  key_chord_detect #(
    .KEYS           (KEYS)
  ) u_keys (
    .keys_pressed_i (keys_pressed_i),
    .chord_o        (keypad_chord_reset),
    .any_key_o      (keypad_irq)
  );

  // ===================================================================
  // Reset merge
  // ===================================================================
  wire supply_low_reset;
  wire supply_ok;

  assign supply_low_reset = ~supply_low_reset_n_i;
  assign supply_ok        = supply_low_reset_n_i;

  // Combinational so it works even while the clock is absent
  assign cpu_reset_out_o = keypad_chord_reset
                           | watchdog_reset_req_i
                           | supply_low_reset;

  // ===================================================================
  // Converter shutdown
  // ===================================================================
  converter_stop_ctrl u_conv (
    .clk_i                  (clk_i),
    .rst_n_i                (rst_n_i),
    .supply_ok_i            (supply_ok),
    .receive_hush_mode_i    (receive_hush_mode_i),
    .radio_receive_active_i (radio_receive_active_i),
    .dummy_load_on_i        (dummy_load_on_i),
    .converter_stop_n_o     (converter_stop_n_o),
    .converter_stop_n_oe_o  (converter_stop_n_oe_o),
    .backup_mode_o          (backup_mode_o)
  );

  // ===================================================================
  // Backup-mode decision for load gating
  // ===================================================================
  wire backup_now;

  assign backup_now = receive_hush_mode_i & radio_receive_active_i
                      & ~dummy_load_on_i;

  // ===================================================================
  // External interrupts
  // ===================================================================
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_irq_in_a_o <= `RST_IRQ;
      cpu_irq_in_b_o <= `RST_IRQ;
      cpu_irq_in_c_o <= `RST_IRQ;
    end else begin
      cpu_irq_in_a_o <= keypad_irq;
      cpu_irq_in_b_o <= ~battery_low_n_i;
      cpu_irq_in_c_o <= serial_chip_irq_i;
    end
  end

  // ===================================================================
  // High-power load gating
  // ===================================================================
  // Requests are only masked, never altered, so they return intact
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      vibrator_en_o  <= `RST_LOAD_EN;
      backlight_en_o <= `RST_LOAD_EN;
    end else if (!supply_ok) begin
      vibrator_en_o  <= `RST_LOAD_EN;
      backlight_en_o <= `RST_LOAD_EN;
    end else begin
      vibrator_en_o  <= vibrator_req_i & ~backup_now;
      backlight_en_o <= backlight_req_i & ~backup_now;
    end
  end

  // ===================================================================
  // End-of-reception restore pulse
  // ===================================================================
  reg backup_prev;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      backup_prev      <= 1'b0;
      loads_restored_o <= 1'b0;
    end else begin
      backup_prev      <= backup_mode_o;
      loads_restored_o <= backup_prev & ~backup_mode_o;
    end
  end

  // ===================================================================
  // Static RAM access enable
  // ===================================================================
  // Gated only by supply state; processor reset leaves RAM untouched
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sram_access_en_o <= 1'b0;
    end else begin
      sram_access_en_o <= supply_ok;
    end
  end

  // ===================================================================
  // Reset cause status
  // ===================================================================
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      reset_cause_o <= 3'h0;
    end else begin
      reset_cause_o <= {supply_low_reset,
                        watchdog_reset_req_i,
                        keypad_chord_reset};
    end
  end

  // ===================================================================
  // RF timing tick
  // ===================================================================
  reg [`RF_CNT_W-1:0] rf_cnt;
  reg [`RF_CNT_W-1:0] next_rf_cnt;

  always @* begin
    if (rf_cnt == RF_LAST) begin
      next_rf_cnt = {`RF_CNT_W{1'b0}};
    end else begin
      next_rf_cnt = rf_cnt + 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rf_cnt    <= {`RF_CNT_W{1'b0}};
      rf_tick_o <= 1'b0;
    end else begin
      rf_cnt    <= next_rf_cnt;
      rf_tick_o <= (rf_cnt == RF_LAST);
    end
  end

endmodule // board_reset_irq_glue

// ### testbench/soft_cpu_model.sv
`timescale 1ns/1ps
// ====================
// Software port model
// ====================
module soft_cpu_model (
  // Software port bits
  input  wire quiet_en_i,
  input  wire wd_miss_i,
  // Device side
  output wire receive_hush_mode_o,
  output wire watchdog_reset_req_o
);
  assign receive_hush_mode_o  = quiet_en_i;
  assign watchdog_reset_req_o = wd_miss_i;
endmodule // soft_cpu_model

// ### testbench/board_glue_chk.sv
`timescale 1ns/1ps
// ====================
// Checker
// ====================
module board_glue_chk #(
  parameter KEYS = 5
) (
  // Inputs
  input wire            clk_i,
  input wire            rst_n_i,
  input wire [KEYS-1:0] keys_pressed_i,
  input wire            watchdog_reset_req_i,
  input wire            supply_low_reset_n_i,
  input wire            receive_hush_mode_i,
  input wire            radio_receive_active_i,
  input wire            dummy_load_on_i,
  input wire            battery_low_n_i,
  input wire            serial_chip_irq_i,
  // Outputs
  input wire            cpu_reset_out_o,
  input wire            converter_stop_n_o,
  input wire            converter_stop_n_oe_o,
  input wire            cpu_irq_in_a_o,
  input wire            cpu_irq_in_b_o,
  input wire            cpu_irq_in_c_o,
  input wire            backup_mode_o,
  input wire            loads_restored_o,
  input wire            sram_access_en_o,
  input wire            rf_tick_o
);
  wire sup = supply_low_reset_n_i;
  wire hush = receive_hush_mode_i && radio_receive_active_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RESET_MERGE: assert property (cpu_reset_out_o == (&keys_pressed_i ||
    watchdog_reset_req_i || !sup)) else $error("reset merge wrong");
  AST_STOP: assert property (sup && hush && !dummy_load_on_i |=>
    !converter_stop_n_o && converter_stop_n_oe_o) else $error("no stop");
  AST_RUN_HIGH: assert property (sup && !(hush && !dummy_load_on_i)
    |=> converter_stop_n_o && converter_stop_n_oe_o) else $error("not run");
  AST_FLOAT: assert property (!sup |=> !converter_stop_n_oe_o)
    else $error("pin driven while supply low");
  AST_KEY_IRQ: assert property (1 |=> cpu_irq_in_a_o ==
    $past(|keys_pressed_i)) else $error("key irq wrong");
  AST_PWR_IRQ: assert property (1 |=> cpu_irq_in_b_o ==
    !$past(battery_low_n_i)) else $error("power irq wrong");
  AST_SER_IRQ: assert property (1 |=> cpu_irq_in_c_o ==
    $past(serial_chip_irq_i)) else $error("serial irq wrong");
  AST_RESTORE: assert property ($fell(backup_mode_o) |=>
    loads_restored_o) else $error("no restore pulse");
  AST_SRAM: assert property (1 |=> sram_access_en_o == $past(sup))
    else $error("ram access wrong");
  AST_TICK: assert property (rf_tick_o |=> !rf_tick_o [*7] ##1
    rf_tick_o) else $error("tick spacing wrong");
  cover property ($fell(backup_mode_o));
  cover property (cpu_reset_out_o && &keys_pressed_i);
  cover property (sup && hush && dummy_load_on_i);
endmodule // board_glue_chk
bind board_reset_irq_glue board_glue_chk #(.KEYS(KEYS)) chk_inst (.*);

// ### testbench/board_reset_irq_glue_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
// ====================
// Bench
// ====================
module board_reset_irq_glue_bench;
  reg         clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [13:0] v = 14'h0000;
  reg  [12:0] e;
  reg  [12:0] q[$];
  reg  [31:0] r;
  reg         p1 = 1'b0;
  reg         p2 = 1'b0;
  integer     cyc = 0;
  integer     err_count = 0;
  integer     checks_done = 0;
  integer     seed = 32'ha508c91a;
  integer     i;
  wire        hush, wd, rst_o, stop_n, oe, ia, ib, ic, ven, ben, sram;
  wire        bk, lr, tick;
  wire [2:0]  cause;
  always #20 clk_i = ~clk_i;
  soft_cpu_model soft_cpu_model_inst (.quiet_en_i(v[6]), .wd_miss_i(v[8]),
    .receive_hush_mode_o(hush), .watchdog_reset_req_o(wd));
  board_reset_irq_glue board_reset_irq_glue_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .keys_pressed_i(v[13:9]),
    .watchdog_reset_req_i(wd), .supply_low_reset_n_i(v[7]),
    .receive_hush_mode_i(hush), .radio_receive_active_i(v[5]),
    .dummy_load_on_i(v[4]), .vibrator_req_i(v[3]),
    .backlight_req_i(v[2]), .battery_low_n_i(v[1]),
    .serial_chip_irq_i(v[0]), .cpu_reset_out_o(rst_o),
    .converter_stop_n_o(stop_n), .converter_stop_n_oe_o(oe),
    .cpu_irq_in_a_o(ia), .cpu_irq_in_b_o(ib), .cpu_irq_in_c_o(ic),
    .vibrator_en_o(ven), .backlight_en_o(ben), .backup_mode_o(bk),
    .loads_restored_o(lr), .sram_access_en_o(sram),
    .reset_cause_o(cause), .rf_tick_o(tick));
  function [12:0] expv(input [13:0] x);
    reg s;
    reg st;
    begin
      s = x[7];
      st = x[6] & x[5] & ~x[4] & s;
      expv = {(&x[13:9]) | x[8] | ~s, ~st, s, |x[13:9], ~x[1], x[0],
        x[3] & s & ~st, x[2] & s & ~st, s, ~s, x[8], &x[13:9], st};
    end
  endfunction
  task drv(input [13:0] x);
    begin
      @(negedge clk_i);
      v = x;
      q.push_back(expv(x));
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Monitor: oldest note against settled outputs
  always @(posedge clk_i) begin
    if (q.size() != 0) begin
      #1;
      e = q.pop_front();
      `CHK("outs", e[12:1], {rst_o, stop_n, oe, ia, ib, ic, ven, ben, sram, cause})
      `CHK("backup", e[0], bk)
      `CHK("restore", p2 & ~p1, lr)
      p2 = p1;
      p1 = e[0];
    end
  end
  // Tick spacing from release of reset
  always @(posedge clk_i) begin
    if (rst_n_i) begin
      cyc = cyc + 1;
      #1;
      `CHK("tick", (cyc % 8 == 0), tick)
    end
  end
  initial begin
    v = 14'h0082;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    @(posedge clk_i);
    drv(14'h00ee);
    drv(14'h00fe);
    drv(14'h00ee);
    drv(14'h00ce);
    drv(14'h008e);
    $display("done quiet");
    for (i = 0; i < 6; i = i + 1)
      drv({(i == 5) ? 5'h1f : (5'h1f & ~(5'h01 << i)), 9'h082});
    $display("done chord");
    drv(14'h0182);
    drv(14'h006e);
    drv(14'h0082);
    $display("done sources");
    repeat (300) begin
      r = $random(seed);
      drv(r[13:0]);
    end
    $display("done random");
    for (i = 0; i < 20 && q.size() != 0; i = i + 1)
      @(posedge clk_i);
    if (q.size() != 0)
      err_count++;
    #2;
    report_and_stop;
  end
endmodule // board_reset_irq_glue_bench
